//--- hw/tpf_pkg.sv
// Constants shared by the timer pin-function select block
package tpf_pkg;

    // Register bus geometry
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 16;

    // Register indices on the plain register port
    localparam logic [3:0] ADDR_CH1_IO_CTL   = 4'h0;
    localparam logic [3:0] ADDR_CH2_IO_CTL   = 4'h1;
    localparam logic [3:0] ADDR_CH3_IO_CTL_H = 4'h2;
    localparam logic [3:0] ADDR_CH0_IO_CTL_L = 4'h3;
    localparam logic [3:0] ADDR_CH0_MODE     = 4'h4;
    localparam logic [3:0] ADDR_CH1_CONTROL  = 4'h5;
    localparam logic [3:0] ADDR_CH4_CONTROL  = 4'h6;
    localparam logic [3:0] ADDR_EVENT_FLAGS  = 4'h7;
    localparam logic [3:0] ADDR_PIN_STATUS   = 4'h8;
    localparam logic [3:0] ADDR_CH0_GEN_D    = 4'h9;
    localparam logic [3:0] ADDR_CH1_GEN_B    = 4'hA;
    localparam logic [3:0] ADDR_CH2_GEN_B    = 4'hB;
    localparam logic [3:0] ADDR_CH3_GEN_B    = 4'hC;

    // Field layout of the 8-bit I/O control registers
    localparam int unsigned FLD_MSB   = 7;
    localparam int unsigned FLD_LSB   = 4;
    localparam int unsigned FLD_CAPT  = 3;
    localparam int unsigned FLD_ALT   = 2;
    localparam int unsigned FLD_BOTH  = 1;
    localparam int unsigned FLD_FALL  = 0;

    // Buffer-mode bit for register D in the channel 0 mode register
    localparam int unsigned BUF_D_BIT = 5;

    // Prescaler select field in the channel control registers
    localparam int unsigned PSC_MSB   = 2;
    localparam int unsigned PSC_LSB   = 0;
    localparam logic [2:0]  PSC_UNDIV = 3'h0;

    // Compare-match actions, two low field bits
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_LOW  = 2'h1;
    localparam logic [1:0] ACT_HIGH = 2'h2;
    localparam logic [1:0] ACT_TGL  = 2'h3;

    // Values after reset
    localparam logic [7:0]  RST_CTL   = 8'h00;
    localparam logic [15:0] RST_GEN   = 16'hFFFF;
    localparam logic [15:0] RST_RDATA = 16'h0000;

endpackage

//--- hw/tpf_chan.sv
// One general register with its pin: compare output or capture input
`timescale 1ns/100ps
`default_nettype none

module tpf_chan #(
    parameter int unsigned CW      = 16,
    parameter bit          HAS_INT = 1'b1
) (
    input  wire logic          clk_i,
    input  wire logic          rst_n_i,
    input  wire logic [3:0]    ctl_i,
    input  wire logic          ctl_wr_i,
    input  wire logic          gr_wr_i,
    input  wire logic [CW-1:0] gr_wdata_i,
    input  wire logic [CW-1:0] cnt_i,
    input  wire logic          pin_i,
    input  wire logic          int_trig_i,
    input  wire logic          inhibit_i,
    output logic               pin_o,
    output logic               pin_oe_o,
    output logic [CW-1:0]      gr_o,
    output logic               match_o,
    output logic               capt_o
);

    logic          pin_s1_reg;
    logic          pin_s2_reg;
    logic          pin_s3_reg;
    logic          eq_reg;
    logic          ctl_wr_d_reg;
    logic          pin_next;
    logic [CW-1:0] gr_next;

    wire cap_mode = ctl_i[tpf_pkg::FLD_CAPT];
    wire int_sel  = HAS_INT & ctl_i[tpf_pkg::FLD_ALT];
    wire rise     = pin_s2_reg & ~pin_s3_reg;
    wire fall     = ~pin_s2_reg & pin_s3_reg;
    wire pin_edge = ctl_i[tpf_pkg::FLD_BOTH] ? (rise | fall)
                  : (ctl_i[tpf_pkg::FLD_FALL] ? fall : rise);
    wire capt_ev  = cap_mode & ~inhibit_i
                  & (int_sel ? int_trig_i : pin_edge);
    wire cnt_eq   = (cnt_i == gr_o);
    // Match only on arrival at the value, not for every cycle it holds
    wire match_ev = ~cap_mode & ~inhibit_i & cnt_eq & ~eq_reg;
    wire out_en   = ~cap_mode & ~inhibit_i
                  & (ctl_i[1:0] != tpf_pkg::ACT_NONE);

    always_comb begin
        pin_next = pin_o;
        // Strobe delayed a cycle so the new code, not the old one, sets the level
        if (ctl_wr_d_reg && !cap_mode) begin
            pin_next = ctl_i[tpf_pkg::FLD_ALT];
        end else if (match_ev) begin
            case (ctl_i[1:0])
                tpf_pkg::ACT_LOW:  pin_next = 1'b0;
                tpf_pkg::ACT_HIGH: pin_next = 1'b1;
                tpf_pkg::ACT_TGL:  pin_next = ~pin_o;
                default:           pin_next = pin_o;
            endcase
        end
    end

    // Hardware capture wins over a software write in the same cycle
    assign gr_next = capt_ev ? cnt_i : (gr_wr_i ? gr_wdata_i : gr_o);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pin_s1_reg <= 1'b0;
            pin_s2_reg <= 1'b0;
            pin_s3_reg <= 1'b0;
            eq_reg     <= 1'b0;
            ctl_wr_d_reg <= 1'b0;
            pin_o      <= 1'b0;
            pin_oe_o   <= 1'b0;
            gr_o       <= tpf_pkg::RST_GEN[CW-1:0];
            match_o    <= 1'b0;
            capt_o     <= 1'b0;
        end else begin
            pin_s1_reg <= pin_i;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            eq_reg     <= cnt_eq;
            ctl_wr_d_reg <= ctl_wr_i;
            pin_o      <= pin_next;
            pin_oe_o   <= out_en;
            gr_o       <= gr_next;
            match_o    <= match_ev;
            capt_o     <= capt_ev;
        end
    end

endmodule

`default_nettype wire

//--- hw/tpf_top.sv
// Pin-function select for general registers B of channels 1-3 and D of channel 0
//
// The address map and strobed register access were decided locally.
`timescale 1ns/100ps
`default_nettype none

module tpf_top #(
    parameter int unsigned CW = 16
) (
    input  wire logic                        MCLK_I,
    input  wire logic                        NRST_I,
    input  wire logic [tpf_pkg::ADDR_W-1:0]  ADDR_I,
    input  wire logic [tpf_pkg::DATA_W-1:0]  WDATA_I,
    input  wire logic                        WR_I,
    input  wire logic                        RD_I,
    output logic      [tpf_pkg::DATA_W-1:0]  RDATA_O,
    input  wire logic [CW-1:0]               CH0_COUNTER_I,
    input  wire logic [CW-1:0]               CH1_COUNTER_I,
    input  wire logic [CW-1:0]               CH2_COUNTER_I,
    input  wire logic [CW-1:0]               CH3_COUNTER_I,
    input  wire logic                        CH1_COUNT_TICK_I,
    input  wire logic                        CH4_COUNT_TICK_I,
    input  wire logic                        CH0_GEN_C_EVENT_I,
    input  wire logic                        CH0_PIN_D_I,
    output logic                             CH0_PIN_D_O,
    output logic                             CH0_PIN_D_OE_O,
    input  wire logic                        CH1_PIN_B_I,
    output logic                             CH1_PIN_B_O,
    output logic                             CH1_PIN_B_OE_O,
    input  wire logic                        CH2_PIN_B_I,
    output logic                             CH2_PIN_B_O,
    output logic                             CH2_PIN_B_OE_O,
    input  wire logic                        CH3_PIN_B_I,
    output logic                             CH3_PIN_B_O,
    output logic                             CH3_PIN_B_OE_O
);

    localparam int unsigned NCH = 4;

    // Software-visible registers
    logic [7:0]                  ctl_reg [NCH];
    logic [7:0]                  ch0_mode_reg;
    logic [7:0]                  ch1_control_reg;
    logic [7:0]                  ch4_control_reg;
    logic [2*NCH-1:0]            flags_reg;
    logic [2*NCH-1:0]            flags_next;
    logic [tpf_pkg::DATA_W-1:0]  rdata_next;

    // Per-slot signals; slot 0 is channel 0 register D, slots 1-3 are channels 1-3
    logic [CW-1:0]  cnt     [NCH];
    logic [CW-1:0]  gr      [NCH];
    logic [NCH-1:0] pin_in;
    logic [NCH-1:0] pin_out;
    logic [NCH-1:0] pin_oe;
    logic [NCH-1:0] int_trig;
    logic [NCH-1:0] inhibit;
    logic [NCH-1:0] match;
    logic [NCH-1:0] capt;
    logic [NCH-1:0] ctl_wr;
    logic [NCH-1:0] gr_wr;

    assign cnt[0] = CH0_COUNTER_I;
    assign cnt[1] = CH1_COUNTER_I;
    assign cnt[2] = CH2_COUNTER_I;
    assign cnt[3] = CH3_COUNTER_I;

    assign pin_in = {CH3_PIN_B_I, CH2_PIN_B_I, CH1_PIN_B_I, CH0_PIN_D_I};

    // Undivided prescaler means the count tick is not a usable capture source
    wire ch1_psc_div = ch1_control_reg[tpf_pkg::PSC_MSB:tpf_pkg::PSC_LSB]
                       != tpf_pkg::PSC_UNDIV;
    wire ch4_psc_div = ch4_control_reg[tpf_pkg::PSC_MSB:tpf_pkg::PSC_LSB]
                       != tpf_pkg::PSC_UNDIV;

    assign int_trig[0] = CH1_COUNT_TICK_I & ch1_psc_div;
    assign int_trig[1] = CH0_GEN_C_EVENT_I;
    assign int_trig[2] = 1'b0;
    assign int_trig[3] = CH4_COUNT_TICK_I & ch4_psc_div;

    assign inhibit[0] = ch0_mode_reg[tpf_pkg::BUF_D_BIT];
    assign inhibit[1] = 1'b0;
    assign inhibit[2] = 1'b0;
    assign inhibit[3] = 1'b0;

    // Address decode
    wire wr_ctl1  = WR_I & (ADDR_I == tpf_pkg::ADDR_CH1_IO_CTL);
    wire wr_ctl2  = WR_I & (ADDR_I == tpf_pkg::ADDR_CH2_IO_CTL);
    wire wr_ctl3  = WR_I & (ADDR_I == tpf_pkg::ADDR_CH3_IO_CTL_H);
    wire wr_ctl0  = WR_I & (ADDR_I == tpf_pkg::ADDR_CH0_IO_CTL_L);
    wire wr_mode0 = WR_I & (ADDR_I == tpf_pkg::ADDR_CH0_MODE);
    wire wr_tcr1  = WR_I & (ADDR_I == tpf_pkg::ADDR_CH1_CONTROL);
    wire wr_tcr4  = WR_I & (ADDR_I == tpf_pkg::ADDR_CH4_CONTROL);
    wire wr_flags = WR_I & (ADDR_I == tpf_pkg::ADDR_EVENT_FLAGS);

    assign ctl_wr = {wr_ctl3, wr_ctl2, wr_ctl1, wr_ctl0};
    assign gr_wr  = {WR_I & (ADDR_I == tpf_pkg::ADDR_CH3_GEN_B),
                     WR_I & (ADDR_I == tpf_pkg::ADDR_CH2_GEN_B),
                     WR_I & (ADDR_I == tpf_pkg::ADDR_CH1_GEN_B),
                     WR_I & (ADDR_I == tpf_pkg::ADDR_CH0_GEN_D)};

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : gen_slot
            tpf_chan #(
                .CW      (CW),
                .HAS_INT (g != 2)
            ) u_chan (
                .clk_i      (MCLK_I),
                .rst_n_i    (NRST_I),
                .ctl_i      (ctl_reg[g][tpf_pkg::FLD_MSB:tpf_pkg::FLD_LSB]),
                .ctl_wr_i   (ctl_wr[g]),
                .gr_wr_i    (gr_wr[g]),
                .gr_wdata_i (WDATA_I[CW-1:0]),
                .cnt_i      (cnt[g]),
                .pin_i      (pin_in[g]),
                .int_trig_i (int_trig[g]),
                .inhibit_i  (inhibit[g]),
                .pin_o      (pin_out[g]),
                .pin_oe_o   (pin_oe[g]),
                .gr_o       (gr[g]),
                .match_o    (match[g]),
                .capt_o     (capt[g])
            );
        end
    endgenerate

    // Pin outputs come straight from the slot flip-flops
    assign CH0_PIN_D_O    = pin_out[0];
    assign CH0_PIN_D_OE_O = pin_oe[0];
    assign CH1_PIN_B_O    = pin_out[1];
    assign CH1_PIN_B_OE_O = pin_oe[1];
    assign CH2_PIN_B_O    = pin_out[2];
    assign CH2_PIN_B_OE_O = pin_oe[2];
    assign CH3_PIN_B_O    = pin_out[3];
    assign CH3_PIN_B_OE_O = pin_oe[3];

    // Sticky event flags, write one to clear; a new event beats the clear
    wire [2*NCH-1:0] flag_set = {capt, match};
    wire [2*NCH-1:0] flag_clr = wr_flags ? WDATA_I[2*NCH-1:0] : '0;
    assign flags_next = (flags_reg & ~flag_clr) | flag_set;

    // Read mux; unmapped addresses read as zero
    always_comb begin
        rdata_next = tpf_pkg::RST_RDATA;
        case (ADDR_I)
            tpf_pkg::ADDR_CH1_IO_CTL:   rdata_next[7:0] = ctl_reg[1];
            tpf_pkg::ADDR_CH2_IO_CTL:   rdata_next[7:0] = ctl_reg[2];
            tpf_pkg::ADDR_CH3_IO_CTL_H: rdata_next[7:0] = ctl_reg[3];
            tpf_pkg::ADDR_CH0_IO_CTL_L: rdata_next[7:0] = ctl_reg[0];
            tpf_pkg::ADDR_CH0_MODE:     rdata_next[7:0] = ch0_mode_reg;
            tpf_pkg::ADDR_CH1_CONTROL:  rdata_next[7:0] = ch1_control_reg;
            tpf_pkg::ADDR_CH4_CONTROL:  rdata_next[7:0] = ch4_control_reg;
            tpf_pkg::ADDR_EVENT_FLAGS:  rdata_next[2*NCH-1:0] = flags_reg;
            tpf_pkg::ADDR_PIN_STATUS:   rdata_next[2*NCH-1:0] = {pin_oe, pin_out};
            tpf_pkg::ADDR_CH0_GEN_D:    rdata_next[CW-1:0] = gr[0];
            tpf_pkg::ADDR_CH1_GEN_B:    rdata_next[CW-1:0] = gr[1];
            tpf_pkg::ADDR_CH2_GEN_B:    rdata_next[CW-1:0] = gr[2];
            tpf_pkg::ADDR_CH3_GEN_B:    rdata_next[CW-1:0] = gr[3];
            default:                    rdata_next = tpf_pkg::RST_RDATA;
        endcase
    end

    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            for (int i = 0; i < NCH; i++) begin
                ctl_reg[i] <= tpf_pkg::RST_CTL;
            end
            ch0_mode_reg    <= tpf_pkg::RST_CTL;
            ch1_control_reg <= tpf_pkg::RST_CTL;
            ch4_control_reg <= tpf_pkg::RST_CTL;
            flags_reg       <= '0;
            RDATA_O         <= tpf_pkg::RST_RDATA;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (ctl_wr[i]) begin
                    ctl_reg[i] <= WDATA_I[7:0];
                end
            end
            if (wr_mode0) begin
                ch0_mode_reg <= WDATA_I[7:0];
            end
            if (wr_tcr1) begin
                ch1_control_reg <= WDATA_I[7:0];
            end
            if (wr_tcr4) begin
                ch4_control_reg <= WDATA_I[7:0];
            end
            flags_reg <= flags_next;
            RDATA_O   <= RD_I ? rdata_next : tpf_pkg::RST_RDATA;
        end
    end

endmodule

`default_nettype wire

//--- verif/tpf_top_chk.sv
// Port-level checks of the pin-function select block
`timescale 1ns/100ps
`default_nettype none
module tpf_top_chk #(
    parameter int unsigned CW = 16
) (
    input wire logic                       MCLK_I,
    input wire logic                       NRST_I,
    input wire logic [tpf_pkg::ADDR_W-1:0] ADDR_I,
    input wire logic [tpf_pkg::DATA_W-1:0] WDATA_I,
    input wire logic                       WR_I,
    input wire logic                       RD_I,
    input wire logic [tpf_pkg::DATA_W-1:0] RDATA_O,
    input wire logic [CW-1:0]              CH1_COUNTER_I,
    input wire logic                       CH1_PIN_B_O,
    input wire logic                       CH1_PIN_B_OE_O,
    input wire logic                       CH0_PIN_D_OE_O
);
    logic [2:0]    wr_sh_reg;
    logic [CW-1:0] gr1_reg;
    // Shadow of channel 1 register B; captures are not tracked
    always_ff @(posedge MCLK_I) begin
        wr_sh_reg <= {wr_sh_reg[1:0], WR_I};
        if (!NRST_I) gr1_reg <= {CW{1'b1}};
        else if (WR_I && ADDR_I == 4'hA) gr1_reg <= WDATA_I[CW-1:0];
    end
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!NRST_I);
    a_rd_idle: assert property (!$past(RD_I) |-> RDATA_O == 16'h0000)
        else $error("read data not zero outside read");
    a_rd_unmapped: assert property (RD_I && ADDR_I > 4'hC |=> RDATA_O == 16'h0000)
        else $error("unmapped read not zero");
    a_reset_quiet: assert property (!$past(NRST_I) |-> !CH1_PIN_B_OE_O && !CH0_PIN_D_OE_O)
        else $error("pin driven after reset");
    a_init_high: assert property (WR_I && ADDR_I == 4'h0 && WDATA_I[7:6] == 2'h1
        && WDATA_I[5:4] != 2'h0 |-> ##2 CH1_PIN_B_O && CH1_PIN_B_OE_O)
        else $error("initial high level missing");
    a_init_low: assert property (WR_I && ADDR_I == 4'h0 && WDATA_I[7:6] == 2'h0
        && WDATA_I[5:4] != 2'h0 |-> ##2 !CH1_PIN_B_O && CH1_PIN_B_OE_O)
        else $error("initial low level missing");
    a_out_off: assert property (WR_I && ADDR_I == 4'h0
        && (WDATA_I[7] || WDATA_I[5:4] == 2'h0) |-> ##2 !CH1_PIN_B_OE_O)
        else $error("pin driven while disabled");
    a_pin_cause: assert property ($changed(CH1_PIN_B_O)
        |-> (|wr_sh_reg) || $past(CH1_COUNTER_I) == gr1_reg)
        else $error("pin changed without match or write");
    a_ctl_readback: assert property (WR_I && ADDR_I == 4'h2 ##2 RD_I && ADDR_I == 4'h2
        |=> RDATA_O == {8'h00, $past(WDATA_I[7:0], 3)})
        else $error("control register readback wrong");
    a_buf_no_oe: assert property (WR_I && ADDR_I == 4'h4 && WDATA_I[5]
        |-> ##2 !CH0_PIN_D_OE_O)
        else $error("buffer mode left pin driven");
endmodule
`default_nettype wire

//--- verif/tpf_far_model.sv
// Far side: pin levels, shared counter and neighbour count ticks
`timescale 1ns/100ps
`default_nettype none
module tpf_far_model (
    input  wire logic        clk_i,
    input  wire logic        run_i,
    input  wire logic [3:0]  lvl_i,
    input  wire logic [3:0]  o_i,
    input  wire logic [3:0]  oe_i,
    output logic      [3:0]  pin_o,
    output logic      [15:0] cnt_o,
    output logic             tick_o
);
    // Counter parks at zero so a match value is only passed once per run
    always_ff @(posedge clk_i) cnt_o <= run_i ? cnt_o + 16'h1 : 16'h0;
    assign tick_o = run_i && cnt_o[1:0] == 2'h3;
    assign pin_o = (oe_i & o_i) | (~oe_i & lvl_i);
endmodule
`default_nettype wire

//--- verif/tb_timer_io_pin_function_select.sv
// Register-level tests of the pin-function select block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin fails++; \
    $display("CHECK FAILED %s expected %h seen %h", n, e, a); end end
module tb_timer_io_pin_function_select;
    logic        mclk, nrst, wr, rd, run, tick;
    logic [3:0]  addr, lvl, pin_i, pin_o, pin_oe;
    logic [15:0] wdata, rdata, cnt, prev, v, t;
    int          fails, checks, c;
    tpf_top dut_u (.MCLK_I(mclk), .NRST_I(nrst), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .CH0_COUNTER_I(cnt), .CH1_COUNTER_I(cnt),
        .CH2_COUNTER_I(cnt), .CH3_COUNTER_I(cnt), .CH1_COUNT_TICK_I(tick),
        .CH4_COUNT_TICK_I(tick), .CH0_GEN_C_EVENT_I(tick), .CH0_PIN_D_I(pin_i[0]),
        .CH0_PIN_D_O(pin_o[0]), .CH0_PIN_D_OE_O(pin_oe[0]), .CH1_PIN_B_I(pin_i[1]),
        .CH1_PIN_B_O(pin_o[1]), .CH1_PIN_B_OE_O(pin_oe[1]), .CH2_PIN_B_I(pin_i[2]),
        .CH2_PIN_B_O(pin_o[2]), .CH2_PIN_B_OE_O(pin_oe[2]), .CH3_PIN_B_I(pin_i[3]),
        .CH3_PIN_B_O(pin_o[3]), .CH3_PIN_B_OE_O(pin_oe[3]));
    tpf_far_model far_u (.clk_i(mclk), .run_i(run), .lvl_i(lvl), .o_i(pin_o),
        .oe_i(pin_oe), .pin_o(pin_i), .cnt_o(cnt), .tick_o(tick));
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk); wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge mclk); wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk); rd <= 1'b1; addr <= a;
        @(posedge mclk); rd <= 1'b0;
        @(negedge mclk); d = rdata;
    endtask
    // Slot 0 is channel 0 register D, slots 1-3 the B registers
    function automatic logic [3:0] ctl_a(input int s);
        return s == 0 ? 4'h3 : 4'(s - 1);
    endfunction
    task automatic pin_step(input int s, input logic lv, input logic hit);
        logic [15:0] d;
        rd_reg(4'(9 + s), prev);
        @(negedge mclk); t = cnt;
        @(posedge mclk); lvl[s] <= lv;
        cyc(8);
        rd_reg(4'(9 + s), v);
        d = v - t;
        `CHK("capture", hit ? (d >= 16'h2 && d <= 16'h8) : (v === prev), 1'b1)
    endtask
    task automatic cap_pin(input int s, input logic [7:0] c, input logic r, input logic f);
        wr_reg(ctl_a(s), {8'h00, c});
        cyc(6);
        pin_step(s, 1'b1, r);
        pin_step(s, 1'b0, f);
    endtask
    task automatic int_step(input int s, input logic [7:0] c, input logic hit);
        wr_reg(ctl_a(s), {8'h00, c});
        cyc(6);
        rd_reg(4'(9 + s), prev);
        cyc(8);
        rd_reg(4'(9 + s), v);
        `CHK("internal capture", v !== prev, hit)
    endtask
    task automatic end_of_test;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // Hang guard
    initial begin
        #200000;
        fails++;
        end_of_test;
    end
    initial begin
        nrst = 1'b0; wr = 1'b0; rd = 1'b0; run = 1'b0; addr = 4'h0; wdata = 16'h0000;
        lvl = 4'h0; fails = 0; checks = 0;
        cyc(4);
        nrst <= 1'b1;
        rd_reg(4'h0, v); `CHK("ctl reset", 16'h0000, v)
        rd_reg(4'hA, v); `CHK("gen reset", 16'hFFFF, v)
        rd_reg(4'hF, v); `CHK("unmapped", 16'h0000, v)
        wr_reg(4'h2, 16'hFF37); rd_reg(4'h2, v); `CHK("ctl rw", 16'h0037, v)
        $display("registers done");
        // Codes alternate the initial level, so a level left from the old code shows
        for (int i = 0; i < 8; i++) begin
            c = (i * 5) % 8;
            cyc(1); run <= 1'b0;
            wr_reg(4'h0, {8'h00, 1'b0, 3'(c), 4'h0});
            cyc(2); @(negedge mclk);
            `CHK("oe", (c % 4) != 0, pin_oe[1])
            if (c % 4 != 0) `CHK("init", 1'(c / 4), pin_o[1])
            wr_reg(4'hA, 16'h0010);
            run <= 1'b1;
            cyc(24); @(negedge mclk);
            if (c % 4 != 0)
                `CHK("match", c % 4 == 3 ? 1'(c < 4) : 1'(c % 4 == 2), pin_o[1])
        end
        rd_reg(4'h8, v); `CHK("pin status", 16'h00A2, v)
        `CHK("pins", 8'hA2, {pin_oe, pin_o})
        rd_reg(4'h7, v); `CHK("flags", 16'h0002, v)
        wr_reg(4'h7, 16'h00FF); rd_reg(4'h7, v); `CHK("flags clear", 16'h0000, v)
        $display("compare done");
        cap_pin(2, 8'h80, 1'b1, 1'b0);
        cap_pin(2, 8'h90, 1'b0, 1'b1);
        cap_pin(2, 8'hA0, 1'b1, 1'b1);
        cap_pin(2, 8'hB0, 1'b1, 1'b1);
        cap_pin(2, 8'hC0, 1'b1, 1'b0);
        cap_pin(2, 8'hD0, 1'b0, 1'b1);
        int_step(2, 8'hC0, 1'b0);
        for (int s = 1; s < 4; s++) cap_pin(s, 8'h80, 1'b1, 1'b0);
        $display("pin capture done");
        int_step(1, 8'hC0, 1'b1);
        wr_reg(4'h6, 16'h0000); int_step(3, 8'hC0, 1'b0);
        wr_reg(4'h6, 16'h0001); int_step(3, 8'hF0, 1'b1);
        wr_reg(4'h5, 16'h0000); int_step(0, 8'hC0, 1'b0);
        wr_reg(4'h5, 16'h0001); int_step(0, 8'hE0, 1'b1);
        $display("internal capture done");
        wr_reg(4'h4, 16'h0020); wr_reg(4'h3, 16'h0010);
        cyc(2); @(negedge mclk);
        `CHK("buffer oe", 1'b0, pin_oe[0])
        cap_pin(0, 8'h80, 1'b0, 1'b0);
        wr_reg(4'h4, 16'h0000);
        cap_pin(0, 8'h80, 1'b1, 1'b0);
        $display("buffer mode done");
        end_of_test;
    end
endmodule
bind tpf_top tpf_top_chk #(.CW(CW)) chk_u (.MCLK_I(MCLK_I), .NRST_I(NRST_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .CH1_COUNTER_I(CH1_COUNTER_I), .CH1_PIN_B_O(CH1_PIN_B_O),
    .CH1_PIN_B_OE_O(CH1_PIN_B_OE_O), .CH0_PIN_D_OE_O(CH0_PIN_D_OE_O));
`default_nettype wire
